/* verilog/ppfg_top.sv */
// port pin function gating: per-pin i/o, pulls, input gating, alternate functions
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module ppfg_top #(
  parameter int unsigned W = ppfg_pkg::PORT_W
) (
  input  wire logic          CLK_SYS,
  input  wire logic          RESET,
  input  wire logic [31:0]   WB_ADR_I,
  input  wire logic [31:0]   WB_DAT_I,
  output logic      [31:0]   WB_DAT_O,
  input  wire logic          WB_WE_I,
  input  wire logic [3:0]    WB_SEL_I,
  input  wire logic          WB_CYC_I,
  input  wire logic          WB_STB_I,
  output logic               WB_ACK_O,
  input  wire logic [W-1:0]  PA_IN,
  output logic      [W-1:0]  PA_OUT,
  output logic      [W-1:0]  PA_OE,
  output logic      [W-1:0]  PA_PULL_UP,
  output logic      [W-1:0]  PA_PULL_DOWN,
  output logic      [W-1:0]  PA_IBUF_EN,
  input  wire logic [W-1:0]  PB_IN,
  output logic      [W-1:0]  PB_OUT,
  output logic      [W-1:0]  PB_OE,
  output logic      [W-1:0]  PB_PULL_UP,
  output logic      [W-1:0]  PB_PULL_DOWN,
  output logic      [W-1:0]  PB_IBUF_EN,
  input  wire logic          CMP_RESULT,
  input  wire logic          TIMER_TWO_PWM,
  input  wire logic          TIMER_THREE_PWM,
  output logic               CRYSTAL_MODE,
  output logic               EXT_RESET_PIN_N,
  output logic               EXT_IRQ_LINE_ZERO,
  output logic               EXT_IRQ_LINE_ONE,
  output logic               WAKE_REQ,
  output logic               IRQ
);
  import ppfg_pkg::*;

  logic [W-1:0]       pa_data_q, pa_dir_q, pa_ph_q, pa_pl_q, pa_die_q;
  logic [W-1:0]       pb_data_q, pb_dir_q, pb_ph_q, pb_pl_q, pb_die_q;
  logic [W-1:0]       pa_prev_q, pb_prev_q;
  logic [ALT_W-1:0]   alt_q;
  logic [ST_W-1:0]    stat_q, mask_q, stat_set;
  logic [W-1:0]       pa_gated, pb_gated, pa_wake_hit, pb_wake_hit;
  logic [W-1:0]       pa_out_d, pa_oe_d, pb_out_d, pb_oe_d;
  logic [7:0]         adr;
  logic               req, wr, ack_q;
  logic [31:0]        rdata_d;
  logic [W-1:0]       pa_wake_en_q, pb_wake_en_q, xtal_pins;
  logic               wr_alt, wr_mask, wr_stat, wr_wake_a, wr_wake_b;

  assign adr = WB_ADR_I[7:0];
  assign req = WB_CYC_I & WB_STB_I & ~ack_q;
  assign wr  = req & WB_WE_I & WB_SEL_I[0];

  // per-register write strobes, decoded once
  assign wr_alt    = wr && (adr == OFS_ALT_SEL);
  assign wr_mask   = wr && (adr == OFS_IRQ_MASK);
  assign wr_stat   = wr && (adr == OFS_IRQ_STAT);
  assign wr_wake_a = wr && (adr == OFS_WAKE_EN_A);
  assign wr_wake_b = wr && (adr == OFS_WAKE_EN_B);

  // input gating: disabled buffers read a constant, never the pin
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_gate
      assign pa_gated[g] = pa_die_q[g] ? PA_IN[g] : GATED_LEVEL;
      assign pb_gated[g] = pb_die_q[g] ? PB_IN[g] : GATED_LEVEL;
    end
  endgenerate
  // pad input buffers follow the input enable registers
  assign PA_IBUF_EN = pa_die_q;
  assign PB_IBUF_EN = pb_die_q;

  // wishbone ack: one cycle after request, dropped next cycle
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end
  assign WB_ACK_O = ack_q;

  // port a configuration registers
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      pa_data_q <= RST_ZERO;
      pa_dir_q  <= RST_ZERO;
      pa_ph_q   <= RST_ZERO;
      pa_pl_q   <= RST_ZERO;
      pa_die_q  <= RST_DIE;
    end else if (wr) begin
      unique case (adr)
        OFS_PA_DATA: pa_data_q <= WB_DAT_I[W-1:0];
        OFS_PA_DIR:  pa_dir_q  <= WB_DAT_I[W-1:0];
        OFS_PA_PH:   pa_ph_q   <= WB_DAT_I[W-1:0];
        OFS_PA_PL:   pa_pl_q   <= WB_DAT_I[W-1:0];
        OFS_PA_DIE:  pa_die_q  <= WB_DAT_I[W-1:0];
        default: ;
      endcase
    end
  end

  // port b configuration registers
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      pb_data_q <= RST_ZERO;
      pb_dir_q  <= RST_ZERO;
      pb_ph_q   <= RST_ZERO;
      pb_pl_q   <= RST_ZERO;
      pb_die_q  <= RST_DIE;
    end else if (wr) begin
      unique case (adr)
        OFS_PB_DATA: pb_data_q <= WB_DAT_I[W-1:0];
        OFS_PB_DIR:  pb_dir_q  <= WB_DAT_I[W-1:0];
        OFS_PB_PH:   pb_ph_q   <= WB_DAT_I[W-1:0];
        OFS_PB_PL:   pb_pl_q   <= WB_DAT_I[W-1:0];
        OFS_PB_DIE:  pb_die_q  <= WB_DAT_I[W-1:0];
        default: ;
      endcase
    end
  end

  // alternate function select; bit 8 sits in lane 1 so a byte write leaves it alone
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      alt_q <= RST_ALT;
    end else if (wr_alt) begin
      alt_q <= {WB_SEL_I[1] ? WB_DAT_I[ALT_W-1:8] : alt_q[ALT_W-1:8], WB_DAT_I[7:0]};
    end
  end

  // interrupt mask
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      mask_q <= '0;
    end else if (wr_mask) begin
      mask_q <= WB_DAT_I[ST_W-1:0];
    end
  end

  // wake enables: a pin switched off here toggles quietly, whatever its input enable
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      pa_wake_en_q <= RST_WAKE_EN;
      pb_wake_en_q <= RST_WAKE_EN;
    end else begin
      if (wr_wake_a) begin
        pa_wake_en_q <= WB_DAT_I[W-1:0];
      end
      if (wr_wake_b) begin
        pb_wake_en_q <= WB_DAT_I[W-1:0];
      end
    end
  end

  // output mux: alternate functions override the port latch where selected
  always_comb begin
    pa_out_d = pa_data_q;
    pa_oe_d  = pa_dir_q;
    pb_out_d = pb_data_q;
    pb_oe_d  = pb_dir_q;
    if (alt_q[ALT_XTAL]) begin
      pa_oe_d[PIN_XIN]  = 1'b0;
      pa_oe_d[PIN_XOUT] = 1'b0; // oscillator cell owns the pad
    end
    if (alt_q[ALT_RST]) begin
      pa_oe_d[PIN_RST] = 1'b0;
    end
    if (alt_q[ALT_CMP]) begin
      pa_out_d[PIN_IRQ0] = CMP_RESULT;
      pa_oe_d[PIN_IRQ0]  = 1'b1;
    end
    if (alt_q[ALT_T2PWM]) begin
      pa_out_d[PIN_T2PWM] = TIMER_TWO_PWM;
      pa_oe_d[PIN_T2PWM]  = 1'b1;
    end
    if (alt_q[ALT_T3PWM]) begin
      pb_out_d[PIN_T3PWM] = TIMER_THREE_PWM;
      pb_oe_d[PIN_T3PWM]  = 1'b1;
    end
  end

  // pad drive registered so outputs come from flip-flops
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      PA_OUT <= '0;
      PA_OE  <= '0;
      PB_OUT <= '0;
      PB_OE  <= '0;
    end else begin
      PA_OUT <= pa_out_d;
      PA_OE  <= pa_oe_d;
      PB_OUT <= pb_out_d;
      PB_OE  <= pb_oe_d;
    end
  end

  // pulls dropped on crystal pins to keep the oscillator load clean
  always_comb begin
    xtal_pins           = '0;
    xtal_pins[PIN_XIN]  = alt_q[ALT_XTAL];
    xtal_pins[PIN_XOUT] = alt_q[ALT_XTAL];
  end

  assign PA_PULL_UP   = pa_ph_q & ~xtal_pins;
  assign PA_PULL_DOWN = pa_pl_q & ~xtal_pins;
  assign PB_PULL_UP   = pb_ph_q;
  assign PB_PULL_DOWN = pb_pl_q;
  assign CRYSTAL_MODE = alt_q[ALT_XTAL];

  // reset pin seen through the gated buffer, held inactive when not selected
  assign EXT_RESET_PIN_N = alt_q[ALT_RST] ? pa_gated[PIN_RST] : 1'b1;

  // interrupt line edge detectors
  ppfg_edge_if irq0_if ();
  ppfg_edge_if irq1_if ();
  assign irq0_if.level       = alt_q[ALT_IRQ0] & pa_gated[PIN_IRQ0];
  assign irq0_if.falling_sel = alt_q[ALT_EDGE0];
  assign irq1_if.level       = alt_q[ALT_IRQ1] & pa_gated[PIN_IRQ1];
  assign irq1_if.falling_sel = alt_q[ALT_EDGE1];
  ppfg_edge_det u_irq0 (.CLK_SYS(CLK_SYS), .RESET(RESET), .e(irq0_if.det));
  ppfg_edge_det u_irq1 (.CLK_SYS(CLK_SYS), .RESET(RESET), .e(irq1_if.det));
  // disabling the line masks out false edges from the gating itself
  assign EXT_IRQ_LINE_ZERO = irq0_if.event_pulse & alt_q[ALT_IRQ0];
  assign EXT_IRQ_LINE_ONE  = irq1_if.event_pulse & alt_q[ALT_IRQ1];

  // wake on toggle: only inputs with their input enable and wake enable set can cause it
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      pa_prev_q <= '0;
      pb_prev_q <= '0;
    end else begin
      pa_prev_q <= pa_gated;
      pb_prev_q <= pb_gated;
    end
  end
  assign pa_wake_hit = (pa_gated ^ pa_prev_q) & pa_die_q & pa_wake_en_q;
  assign pb_wake_hit = (pb_gated ^ pb_prev_q) & pb_die_q & pb_wake_en_q;
  assign WAKE_REQ    = |{pa_wake_hit, pb_wake_hit};

  // events that latch into status
  assign stat_set = {WAKE_REQ, EXT_IRQ_LINE_ONE, EXT_IRQ_LINE_ZERO};

  // sticky status: set wins over a write-one clear, so an event in the clear cycle is kept
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~(wr_stat ? WB_DAT_I[ST_W-1:0] : '0)) | stat_set;
    end
  end
  // level interrupt while any unmasked status bit is set
  assign IRQ = |(stat_q & mask_q);

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = '0;
    unique case (adr)
      OFS_PA_DATA:  rdata_d[W-1:0]     = pa_data_q;
      OFS_PA_DIR:   rdata_d[W-1:0]     = pa_dir_q;
      OFS_PA_PH:    rdata_d[W-1:0]     = pa_ph_q;
      OFS_PA_PL:    rdata_d[W-1:0]     = pa_pl_q;
      OFS_PA_DIE:   rdata_d[W-1:0]     = pa_die_q;
      OFS_PB_DATA:  rdata_d[W-1:0]     = pb_data_q;
      OFS_PB_DIR:   rdata_d[W-1:0]     = pb_dir_q;
      OFS_PB_PH:    rdata_d[W-1:0]     = pb_ph_q;
      OFS_PB_PL:    rdata_d[W-1:0]     = pb_pl_q;
      OFS_PB_DIE:   rdata_d[W-1:0]     = pb_die_q;
      OFS_PA_IN:    rdata_d[W-1:0]     = pa_gated;
      OFS_PB_IN:    rdata_d[W-1:0]     = pb_gated;
      OFS_ALT_SEL:  rdata_d[ALT_W-1:0] = alt_q;
      OFS_IRQ_STAT: rdata_d[ST_W-1:0]  = stat_q;
      OFS_IRQ_MASK: rdata_d[ST_W-1:0]  = mask_q;
      OFS_WAKE_EN_A: rdata_d[W-1:0]    = pa_wake_en_q;
      OFS_WAKE_EN_B: rdata_d[W-1:0]    = pb_wake_en_q;
      default:      rdata_d            = '0;
    endcase
  end

  // read data registered alongside ack
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      WB_DAT_O <= '0;
    end else if (req) begin
      WB_DAT_O <= rdata_d;
    end
  end
endmodule : ppfg_top

/* verilog/ppfg_pkg.sv */
// package for the port pin function gating block: register map, fields, reset values
package ppfg_pkg;
  localparam int unsigned PORT_W = 8;
  // register word offsets (byte addresses on wishbone)
  localparam logic [7:0] OFS_PA_DATA   = 8'h00;
  localparam logic [7:0] OFS_PA_DIR    = 8'h04;
  localparam logic [7:0] OFS_PA_PH     = 8'h08;
  localparam logic [7:0] OFS_PA_PL     = 8'h0C;
  localparam logic [7:0] OFS_PA_DIE    = 8'h10;
  localparam logic [7:0] OFS_PB_DATA   = 8'h14;
  localparam logic [7:0] OFS_PB_DIR    = 8'h18;
  localparam logic [7:0] OFS_PB_PH     = 8'h1C;
  localparam logic [7:0] OFS_PB_PL     = 8'h20;
  localparam logic [7:0] OFS_PB_DIE    = 8'h24;
  localparam logic [7:0] OFS_PA_IN     = 8'h28;
  localparam logic [7:0] OFS_PB_IN     = 8'h2C;
  localparam logic [7:0] OFS_ALT_SEL   = 8'h30;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h34;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h38;
  localparam logic [7:0] OFS_WAKE_EN_A = 8'h3C;
  localparam logic [7:0] OFS_WAKE_EN_B = 8'h40;
  // alternate select fields
  localparam int unsigned ALT_XTAL     = 0;
  localparam int unsigned ALT_RST      = 1;
  localparam int unsigned ALT_IRQ0     = 2;
  localparam int unsigned ALT_IRQ1     = 3;
  localparam int unsigned ALT_CMP      = 4;
  localparam int unsigned ALT_T2PWM    = 5;
  localparam int unsigned ALT_T3PWM    = 6;
  localparam int unsigned ALT_EDGE0    = 7;  // 1 = falling edge
  localparam int unsigned ALT_EDGE1    = 8;
  localparam int unsigned ALT_W        = 9;
  // pin positions
  localparam int unsigned PIN_XIN      = 7;
  localparam int unsigned PIN_XOUT     = 6;
  localparam int unsigned PIN_RST      = 5;
  localparam int unsigned PIN_IRQ1     = 4;
  localparam int unsigned PIN_T2PWM    = 3;
  localparam int unsigned PIN_IRQ0     = 0;
  localparam int unsigned PIN_T3PWM    = 7;
  // status bits
  localparam int unsigned ST_IRQ0      = 0;
  localparam int unsigned ST_IRQ1      = 1;
  localparam int unsigned ST_WAKE      = 2;
  localparam int unsigned ST_W         = 3;
  // reset values
  localparam logic [7:0] RST_DIE       = 8'hFF;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [ALT_W-1:0] RST_ALT = 9'h000;
  localparam logic [7:0] RST_WAKE_EN   = 8'hFF;  // every pin may wake until software says otherwise
  localparam logic       GATED_LEVEL   = 1'b0;  // value read for a disabled input
endpackage : ppfg_pkg

/* verilog/ppfg_edge_if.sv */
// interface carrying one gated input and its edge detector result
`timescale 1ns/1ps
interface ppfg_edge_if;
  logic level;
  logic falling_sel;
  logic event_pulse;
  modport src (output level, output falling_sel, input event_pulse);
  modport det (input level, input falling_sel, output event_pulse);
endinterface : ppfg_edge_if

/* verilog/ppfg_edge_det.sv */
// edge detector for one external interrupt line, edge chosen by a select bit
`timescale 1ns/1ps
module ppfg_edge_det (
  input  wire logic CLK_SYS,
  input  wire logic RESET,
  ppfg_edge_if.det  e
);
  import ppfg_pkg::*;
  logic prev_q;

  // previous level kept for edge compare
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      prev_q <= GATED_LEVEL;
    end else begin
      prev_q <= e.level;
    end
  end

  // one pulse per accepted edge
  assign e.event_pulse = e.falling_sel ? (prev_q & ~e.level) : (~prev_q & e.level);
endmodule : ppfg_edge_det

/* sim/ppfg_board.sv */
// board model: pad levels seen by the port from drive, pulls and outside source
`timescale 1ns/1ps
module ppfg_board (
  input  wire logic [7:0] drv,
  input  wire logic [7:0] oe,
  input  wire logic [7:0] pu,
  input  wire logic [7:0] pd,
  input  wire logic [7:0] ext,
  output logic      [7:0] pad
);
  // a driven pin wins, then a pull, else the outside level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad[i] = oe[i] ? drv[i] : pu[i] ? 1'b1 : pd[i] ? 1'b0 : ext[i];
    end
  end
endmodule : ppfg_board

/* sim/ppfg_checker.sv */
// concurrent checks on the port pin function gating ports
`timescale 1ns/1ps
module ppfg_checker
  import ppfg_pkg::*;
#(
  parameter int unsigned W = ppfg_pkg::PORT_W
) (
  input wire logic         CLK_SYS,
  input wire logic         RESET,
  input wire logic [31:0]  WB_ADR_I,
  input wire logic [31:0]  WB_DAT_I,
  input wire logic         WB_WE_I,
  input wire logic [3:0]   WB_SEL_I,
  input wire logic         WB_CYC_I,
  input wire logic         WB_STB_I,
  input wire logic         WB_ACK_O,
  input wire logic [W-1:0] PA_IN,
  input wire logic [W-1:0] PA_OE,
  input wire logic [W-1:0] PA_PULL_UP,
  input wire logic [W-1:0] PA_PULL_DOWN,
  input wire logic [W-1:0] PA_IBUF_EN,
  input wire logic [W-1:0] PB_OE,
  input wire logic [W-1:0] PB_IBUF_EN,
  input wire logic         CRYSTAL_MODE,
  input wire logic         EXT_RESET_PIN_N,
  input wire logic         EXT_IRQ_LINE_ZERO,
  input wire logic         EXT_IRQ_LINE_ONE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // write as the master sees it acknowledged
  wire logic wr = WB_ACK_O && WB_WE_I && WB_SEL_I[0];
  wire logic [7:0] ofs = WB_ADR_I[7:0];
  property p_ack_answer; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no ack after request");
  property p_ack_one; WB_ACK_O |=> !WB_ACK_O; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  // bit 7 left out: it may carry the pwm override
  property p_pb_dir; wr && ofs == OFS_PB_DIR |-> ##2 PB_OE[6:0] == $past(WB_DAT_I[6:0], 2); endproperty
  a_pb_dir: assert property (p_pb_dir) else $error("port b drive enables wrong");
  property p_pb_die; wr && ofs == OFS_PB_DIE |-> ##2 PB_IBUF_EN == $past(WB_DAT_I[7:0], 2); endproperty
  a_pb_die: assert property (p_pb_die) else $error("port b input enables wrong");
  property p_xtal; CRYSTAL_MODE [*2] |-> !PA_OE[7:6] && !PA_PULL_UP[7:6] && !PA_PULL_DOWN[7:6]; endproperty
  a_xtal: assert property (p_xtal) else $error("crystal pins still driven or pulled");
  property p_rst_pin; (PA_IBUF_EN[5] && PA_IN[5]) [*4] |-> EXT_RESET_PIN_N; endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("reset asserted with pin high");
  // four cycles cover the edge detector's previous-level register
  property p_gate0; (!PA_IBUF_EN[0]) [*4] |-> !EXT_IRQ_LINE_ZERO; endproperty
  a_gate0: assert property (p_gate0) else $error("line zero fired from gated pin");
  property p_gate1; (!PA_IBUF_EN[4]) [*4] |-> !EXT_IRQ_LINE_ONE; endproperty
  a_gate1: assert property (p_gate1) else $error("line one fired from gated pin");
  property p_one_edge; EXT_IRQ_LINE_ZERO |=> !EXT_IRQ_LINE_ZERO; endproperty
  a_one_edge: assert property (p_one_edge) else $error("line zero fired twice in a row");
  c_irq0: cover property (EXT_IRQ_LINE_ZERO);
  c_irq1: cover property (EXT_IRQ_LINE_ONE);
  c_rst: cover property (!EXT_RESET_PIN_N);
endmodule : ppfg_checker

bind ppfg_top ppfg_checker #(.W(W)) u_chk (.*);

/* sim/ppfg_bench.sv */
// self-checking bench for the port pin function gating block
`timescale 1ns/1ps
module ppfg_bench;
  import ppfg_pkg::*;
  logic        CLK_SYS = 1'b0;
  logic        RESET = 1'b1;
  logic [31:0] WB_ADR_I = 32'h0000_0000;
  logic [31:0] WB_DAT_I = 32'h0000_0000;
  logic        WB_WE_I = 1'b0;
  logic [3:0]  WB_SEL_I = 4'hF;
  logic        WB_CYC_I = 1'b0;
  logic        WB_STB_I = 1'b0;
  logic        CMP_RESULT = 1'b0;
  logic        TIMER_TWO_PWM = 1'b0;
  logic        TIMER_THREE_PWM = 1'b0;
  logic [7:0]  ext_a = 8'h00;
  logic [7:0]  ext_b = 8'h00;
  logic [31:0] WB_DAT_O;
  logic        WB_ACK_O, CRYSTAL_MODE, EXT_RESET_PIN_N, EXT_IRQ_LINE_ZERO, EXT_IRQ_LINE_ONE, WAKE_REQ, IRQ;
  logic [7:0]  PA_IN, PA_OUT, PA_OE, PA_PULL_UP, PA_PULL_DOWN, PA_IBUF_EN;
  logic [7:0]  PB_IN, PB_OUT, PB_OE, PB_PULL_UP, PB_PULL_DOWN, PB_IBUF_EN;
  logic [7:0]  exp_q[$];
  logic [7:0]  pe;
  logic [31:0] r;
  int          seed, num_errors, compares, c, n[2];

  always #5 CLK_SYS = ~CLK_SYS;
  ppfg_top dut (.*);
  ppfg_board brd_a (.drv(PA_OUT), .oe(PA_OE), .pu(PA_PULL_UP), .pd(PA_PULL_DOWN), .ext(ext_a), .pad(PA_IN));
  ppfg_board brd_b (.drv(PB_OUT), .oe(PB_OE), .pu(PB_PULL_UP), .pd(PB_PULL_DOWN), .ext(ext_b), .pad(PB_IN));

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic final_report(input int lost);
    num_errors += lost;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  task automatic tick(input int k);
    repeat (k) @(posedge CLK_SYS);
  endtask : tick

  // one classic cycle; a missing ack ends the run as a failure
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s = 4'hF);
    int k;
    k = 0;
    @(posedge CLK_SYS);
    WB_ADR_I <= {24'h00_0000, a};
    WB_WE_I <= w;
    WB_SEL_I <= s;
    WB_DAT_I <= d;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    do @(posedge CLK_SYS); while (WB_ACK_O !== 1'b1 && ++k < 50);
    if (WB_ACK_O !== 1'b1) final_report(1);
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    wb(a, 1'b0, 32'h0000_0000);
  endtask : rd

  // edge counters, and the read checker taking the oldest note
  always @(posedge CLK_SYS) begin
    n[0] <= n[0] + EXT_IRQ_LINE_ZERO;
    n[1] <= n[1] + EXT_IRQ_LINE_ONE;
    if (WB_ACK_O === 1'b1 && !WB_WE_I) chk("read", exp_q.size() ? exp_q.pop_front() : 8'hEE, WB_DAT_O[7:0]);
  end

  initial begin
    seed = 21;
    tick(5);
    RESET <= 1'b0;
    rd(OFS_PA_DIE, RST_DIE);
    rd(OFS_PB_DIR, RST_ZERO);
    rd(8'hFC, 8'h00);
    rd(OFS_WAKE_EN_A, RST_WAKE_EN);
    // a write without lane 0 selected must be ignored
    wb(OFS_PA_DATA, 1'b1, 32'h0000_00A5, 4'h2);
    rd(OFS_PA_DATA, 8'h00);
    // random drive, data, pull-ups and outside levels on port b
    r = $random(seed);
    ext_b <= r[31:24];
    wb(OFS_PB_DIR, 1'b1, r);
    wb(OFS_PB_DATA, 1'b1, r >> 8);
    wb(OFS_PB_PH, 1'b1, r >> 16);
    pe = (r[7:0] & r[15:8]) | (~r[7:0] & (r[23:16] | r[31:24]));
    rd(OFS_PB_IN, pe);
    wb(OFS_PB_DIE, 1'b1, 32'h0000_000F);
    rd(OFS_PB_IN, pe & 8'h0F);
    wb(OFS_PB_PL, 1'b1, 32'h0000_00F0);
    chk("pb_pd", 8'hF0, PB_PULL_DOWN);
    wb(OFS_IRQ_MASK, 1'b1, 32'h0000_0003);
    // each line, each edge: wake status stays masked
    for (int ln = 0; ln < 2; ln++) begin
      for (int f = 0; f < 2; f++) begin
        wb(OFS_ALT_SEL, 1'b1, (32'h0000_0004 << ln) | (f << (7 + ln)));
        c = n[ln];
        ext_a[ln * 4] <= 1'b1;
        tick(4);
        chk("rise", 8'(!f), 8'(n[ln] - c));
        ext_a[ln * 4] <= 1'b0;
        tick(4);
        chk("edges", 8'h01, 8'(n[ln] - c));
        chk("irq", 8'h01, 8'(IRQ));
        rd(OFS_IRQ_STAT, 8'(4 | (1 << ln)));
        wb(OFS_IRQ_STAT, 1'b1, 32'h0000_0007);
        tick(2);
        chk("irq_clear", 8'h00, 8'(IRQ));
      end
    end
    // gated pins must not fire or wake
    wb(OFS_ALT_SEL, 1'b1, 32'h0000_000C);
    wb(OFS_PA_DIE, 1'b1, 32'h0000_00EE);
    c = n[0] + n[1];
    ext_a <= 8'h11;
    tick(4);
    ext_a <= 8'h00;
    tick(4);
    chk("gated", 8'h00, 8'(n[0] + n[1] - c));
    rd(OFS_IRQ_STAT, 8'h00);
    // wake enable off: an enabled input toggles without waking
    wb(OFS_WAKE_EN_A, 1'b1, 32'h0000_0000);
    ext_a <= 8'h04;
    tick(4);
    ext_a <= 8'h00;
    tick(4);
    rd(OFS_IRQ_STAT, 8'h00);
    wb(OFS_WAKE_EN_A, 1'b1, 32'h0000_00FF);
    // crystal: software clears bits 7:6 of the input enables first
    wb(OFS_PA_DIE, 1'b1, 32'h0000_003F);
    wb(OFS_PA_PH, 1'b1, 32'h0000_00FF);
    wb(OFS_PA_DIR, 1'b1, 32'h0000_00FF);
    wb(OFS_ALT_SEL, 1'b1, 32'h0000_0001);
    tick(2);
    chk("xtal", 8'h01, 8'(CRYSTAL_MODE));
    chk("xtal_oe", 8'h3F, PA_OE);
    chk("xtal_pu", 8'h3F, PA_PULL_UP);
    wb(OFS_PA_PH, 1'b1, 32'h0000_0000);
    wb(OFS_PA_DIR, 1'b1, 32'h0000_0000);
    wb(OFS_ALT_SEL, 1'b1, 32'h0000_0002);
    ext_a[5] <= 1'b0;
    tick(4);
    chk("rst_low", 8'h00, 8'(EXT_RESET_PIN_N));
    ext_a[5] <= 1'b1;
    tick(4);
    chk("rst_high", 8'h01, 8'(EXT_RESET_PIN_N));
    // comparator and pwm routed onto their pins
    wb(OFS_PA_DIR, 1'b1, 32'h0000_00FF);
    wb(OFS_PB_DIR, 1'b1, 32'h0000_00FF);
    wb(OFS_ALT_SEL, 1'b1, 32'h0000_0070);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      {CMP_RESULT, TIMER_TWO_PWM, TIMER_THREE_PWM} <= r[2:0];
      tick(3);
      chk("cmp_pin", 8'(r[2]), 8'(PA_OUT[0]));
      chk("t2_pin", 8'(r[1]), 8'(PA_OUT[3]));
      chk("t3_pin", 8'(r[0]), 8'(PB_OUT[7]));
    end
    final_report(0);
  end
endmodule : ppfg_bench
